// ==== verilog/tac_pkg.sv ====
// package: constants and carrier types of the conversion controller
package tac_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 10;
   localparam int T_BUS_DLY_NS = 3000;
   localparam int T_CONV_AIN_NS = 15000;
   localparam int T_CONV_TEMP_NS = 30000;
   localparam int T_AUTO_NS = 355000;
   localparam int T_ACQ_NS = 400;
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] DLY_CYC = CNT_W'((T_BUS_DLY_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] CONV_AIN_CYC = CNT_W'((T_CONV_AIN_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] CONV_TEMP_CYC = CNT_W'((T_CONV_TEMP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] AUTO_CYC = CNT_W'((T_AUTO_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

   // ----------------------------------------------------------------
   // register pointers, fields, reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] P_TEMP = 3'h0;
   localparam logic [2:0] P_CFG = 3'h1;
   localparam logic [2:0] P_THYST = 3'h2;
   localparam logic [2:0] P_TOTI = 3'h3;
   localparam logic [2:0] P_ADC = 3'h4;
   localparam logic [2:0] P_CFG2 = 3'h5;
   localparam int CFG_SHDN_BIT = 0;
   localparam int CFG_CH_LSB = 5;
   localparam int CFG2_PIN_BIT = 7;
   localparam int SETPT_LSB = 7;
   localparam logic [2:0] CHAN_TEMP = 3'h0;
   localparam logic [5:0] RESULT_PAD = 6'h00;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] CFG2_RST = 8'h00;
   localparam logic [15:0] THYST_RST = 16'h0000;
   localparam logic [15:0] TOTI_RST = 16'h0000;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [1:0] WB_PTR = 2'h0;
   localparam logic [1:0] WB_FIRST = 2'h1;
   localparam logic [1:0] WB_SECOND = 2'h2;

   // ----------------------------------------------------------------
   // carrier: settings passed from the serial side to the converter side
   // ----------------------------------------------------------------
   typedef struct packed {
      logic shutdown;
      logic pin_mode;
      logic [2:0] channel;
      logic [8:0] toti;
   } tac_cfg_t;
endpackage

// ==== verilog/tac_conv_ctrl.sv ====
// conversion controller with two-wire serial register port
//
// Behaviour
// - falling conversion-start pin puts track-and-hold in hold and starts a conversion
// - in automatic mode every addressed bus transaction that finishes while the converter is idle launches a conversion
// - in automatic mode the conversion oscillator restarts when a transaction ends
// - about 3 us after a transaction, hold and start converting
// - result ready 15 us after start on inputs, 30 us on temperature
// - channel zero routes the temperature sensor to the converter
// - temperature results are 10-bit twos complement, 0.25 C per step
// - temperature result sits in the ten top bits of register 00h
// - overtemperature flag compares each channel zero code with the limit register
// - three address-select pins give the low three bits of the bus address
// - all registers are read over the serial bus by the master, all but 00h and 04h are also written
// - reference amplifier is on only while a conversion runs
// - grounded reference pin selects internal reference, else it is shut down
// - conversion circuitry powers down when each conversion completes
// - a programmable shutdown mode saves power at slow rates
// - conversion clock is internal; the bus clock serves only the serial port
// - configuration bit zero set to one selects shutdown, default zero
// - configuration bits seven to five select the channel, zero is temperature
// - second configuration bit seven low converts every 355 us, high pin only
`timescale 1ns/1ps
`default_nettype none
module tac_conv_ctrl
   import tac_pkg::*;
#(
   parameter logic [3:0] ADDR_BASE = 4'h9 // arbitrary value
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic link_clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic conversion_start_pin_i,
   input wire logic reference_input_pin_grounded_i,
   input wire logic bus_addr_select_bit0_i,
   input wire logic bus_addr_select_bit1_i,
   input wire logic bus_addr_select_bit2_i,
   input wire logic [9:0] adc_code_i,
   output logic track_hold_o,
   output logic [2:0] mux_sel_o,
   output logic ref_amp_on_o,
   output logic reference_switch_o,
   output logic conv_power_o,
   output logic conv_osc_en_o,
   output logic over_temp_o
);
   // ----------------------------------------------------------------
   // serial side: synchronisers and bus conditions
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {L_IDLE, L_ADDR, L_ACK, L_WRITE, L_READ, L_RACK} tac_lst_t;
   tac_lst_t lst;
   logic [2:0] scl_q, sda_q, apin_q1, apin_q2, rt_q;
   logic [7:0] shreg, cfg, cfg2;
   logic [15:0] thyst, toti, temp_l, adc_l;
   logic [3:0] bit_cnt;
   logic [2:0] ptr;
   logic [1:0] wbyte;
   logic rw, rbyte, drv, addressed, done_tgl, cfg_tgl;
   logic [15:0] temp_m, adc_m;
   logic res_tgl;

   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
         apin_q1 <= 3'h0;
         apin_q2 <= 3'h0;
         rt_q <= 3'h0;
      end else begin
         scl_q <= {scl_q[1:0], scl_i};
         sda_q <= {sda_q[1:0], sda_i};
         apin_q1 <= {bus_addr_select_bit2_i, bus_addr_select_bit1_i, bus_addr_select_bit0_i};
         apin_q2 <= apin_q1;
         rt_q <= {rt_q[1:0], res_tgl};
      end
   end

   wire scl_s = scl_q[1];
   wire sda_s = sda_q[1];
   wire scl_rise = scl_q[1] & ~scl_q[2];
   wire scl_fall = ~scl_q[1] & scl_q[2];
   wire start_det = scl_s & scl_q[2] & ~sda_q[1] & sda_q[2];
   wire stop_det = scl_s & scl_q[2] & sda_q[1] & ~sda_q[2];
   wire res_evt = rt_q[1] ^ rt_q[2];
   wire [6:0] my_addr = {ADDR_BASE, apin_q2};
   wire is16 = (ptr == P_TEMP) | (ptr == P_THYST) | (ptr == P_TOTI) | (ptr == P_ADC);
   wire [15:0] rd_word = (ptr == P_TEMP) ? temp_l : (ptr == P_THYST) ? thyst :
                         (ptr == P_TOTI) ? toti : (ptr == P_ADC) ? adc_l : WORD_ZERO;
   wire [7:0] rd_narrow = (ptr == P_CFG) ? cfg : (ptr == P_CFG2) ? cfg2 : 8'h00;
   wire [7:0] rd_byte = !is16 ? rd_narrow : (rbyte ? rd_word[7:0] : rd_word[15:8]);
   wire last_bit = (bit_cnt == BITS_PER_BYTE);

   // ----------------------------------------------------------------
   // serial side: slave state machine and registers
   // ----------------------------------------------------------------
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lst <= L_IDLE;
         shreg <= 8'h00;
         bit_cnt <= 4'h0;
         ptr <= P_TEMP;
         wbyte <= WB_PTR;
         rw <= 1'b0;
         rbyte <= 1'b0;
         drv <= 1'b0;
         addressed <= 1'b0;
         done_tgl <= 1'b0;
         cfg_tgl <= 1'b0;
         cfg <= CFG_RST;
         cfg2 <= CFG2_RST;
         thyst <= THYST_RST;
         toti <= TOTI_RST;
         temp_l <= WORD_ZERO;
         adc_l <= WORD_ZERO;
      end else begin
         if (res_evt) begin
            temp_l <= temp_m;
            adc_l <= adc_m;
         end
         if (start_det) begin
            lst <= L_ADDR;
            bit_cnt <= 4'h0;
            drv <= 1'b0;
            wbyte <= WB_PTR;
            rbyte <= 1'b0;
         end else if (stop_det) begin
            lst <= L_IDLE;
            drv <= 1'b0;
            addressed <= 1'b0;
            if (addressed) begin
               done_tgl <= ~done_tgl;
            end
         end else if (scl_rise) begin
            if (lst == L_ADDR || lst == L_WRITE) begin
               shreg <= {shreg[6:0], sda_s};
            end
            if (lst == L_ADDR || lst == L_WRITE || lst == L_READ) begin
               bit_cnt <= bit_cnt + CNT_ONE[3:0];
            end
            if (lst == L_RACK && sda_s) begin
               lst <= L_IDLE;
            end
         end else if (scl_fall) begin
            unique case (lst)
               L_IDLE: begin
               end
               L_ADDR: begin
                  if (last_bit && shreg[7:1] == my_addr) begin
                     addressed <= 1'b1;
                     rw <= shreg[0];
                     drv <= 1'b1;
                     lst <= L_ACK;
                  end else if (last_bit) begin
                     lst <= L_IDLE;
                  end
               end
               L_WRITE: begin
                  if (last_bit) begin
                     drv <= 1'b1;
                     cfg_tgl <= ~cfg_tgl;
                     lst <= L_ACK;
                     if (wbyte != WB_SECOND) begin
                        wbyte <= wbyte + CNT_ONE[1:0];
                     end
                     if (wbyte == WB_PTR) begin
                        ptr <= shreg[2:0];
                     end else if (ptr == P_CFG && wbyte == WB_FIRST) begin
                        cfg <= shreg;
                     end else if (ptr == P_CFG2 && wbyte == WB_FIRST) begin
                        cfg2 <= shreg;
                     end else if (ptr == P_THYST) begin
                        if (wbyte == WB_FIRST) thyst[15:8] <= shreg;
                        else thyst[7:0] <= shreg;
                     end else if (ptr == P_TOTI) begin
                        if (wbyte == WB_FIRST) toti[15:8] <= shreg;
                        else toti[7:0] <= shreg;
                     end
                  end
               end
               L_ACK: begin
                  bit_cnt <= 4'h0;
                  if (rw) begin
                     shreg <= rd_byte;
                     rbyte <= ~rbyte;
                     lst <= L_READ;
                  end else begin
                     drv <= 1'b0;
                     lst <= L_WRITE;
                  end
               end
               L_READ: begin
                  if (last_bit) begin
                     drv <= 1'b0;
                     lst <= L_RACK;
                  end else begin
                     shreg <= {shreg[6:0], 1'b0};
                  end
               end
               L_RACK: begin
                  bit_cnt <= 4'h0;
                  shreg <= rd_byte;
                  rbyte <= ~rbyte;
                  drv <= 1'b1;
                  lst <= L_READ;
               end
            endcase
         end
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_n_o = ~(drv & ((lst == L_ACK) | ~shreg[7]));

   // settings handed to the converter side
   wire tac_cfg_t cfg_l = '{shutdown: cfg[CFG_SHDN_BIT], pin_mode: cfg2[CFG2_PIN_BIT],
                            channel: cfg[CFG_CH_LSB +: 3], toti: toti[SETPT_LSB +: 9]};

   // ----------------------------------------------------------------
   // converter side: synchronisers
   // ----------------------------------------------------------------
   tac_cfg_t cfg_m;
   logic [2:0] cp_q, dt_q, ct_q;
   logic [1:0] ref_q;

   wire cfg_evt = ct_q[1] ^ ct_q[2];

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ct_q <= 3'h0;
         cfg_m <= '0;
         cp_q <= 3'h7;
         dt_q <= 3'h0;
         ref_q <= 2'h0;
      end else begin
         ct_q <= {ct_q[1:0], cfg_tgl};
         if (cfg_evt) begin
            cfg_m <= cfg_l; // settings stable since the toggle
         end
         cp_q <= {cp_q[1:0], conversion_start_pin_i};
         dt_q <= {dt_q[1:0], done_tgl};
         ref_q <= {ref_q[0], reference_input_pin_grounded_i};
      end
   end

   // ----------------------------------------------------------------
   // converter side: sequencer
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {M_IDLE, M_DELAY, M_CONV} tac_mst_t;
   tac_mst_t mst;
   logic [CNT_W-1:0] cnt, per_cnt;
   logic [2:0] chan_l;

   wire pin_fall = cp_q[2] & ~cp_q[1];
   wire bus_evt = dt_q[1] ^ dt_q[2];
   wire auto_ok = ~cfg_m.pin_mode & ~cfg_m.shutdown;
   wire per_hit = auto_ok & (per_cnt == AUTO_CYC - CNT_ONE);
   wire is_temp = (chan_l == CHAN_TEMP);
   wire [CNT_W-1:0] conv_len = is_temp ? CONV_TEMP_CYC : CONV_AIN_CYC;
   wire conv_end = (mst == M_CONV) & (cnt == conv_len - CNT_ONE);
   wire dly_end = (mst == M_DELAY) & (cnt == DLY_CYC - CNT_ONE);
   wire go_conv = ((mst == M_IDLE) & (pin_fall | (per_hit & ~bus_evt))) | dly_end;
   wire internal_ref = ref_q[1];

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mst <= M_IDLE;
         cnt <= '0;
         chan_l <= CHAN_TEMP;
      end else if (go_conv) begin
         mst <= M_CONV;
         cnt <= '0;
         chan_l <= cfg_m.channel;
      end else if (mst == M_IDLE && auto_ok && bus_evt) begin
         mst <= M_DELAY;
         cnt <= '0;
      end else if (conv_end) begin
         mst <= M_IDLE;
      end else if (mst != M_IDLE) begin
         cnt <= cnt + CNT_ONE;
      end
   end

   // oscillator period restarts at each transaction end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         per_cnt <= '0;
      end else if (!auto_ok || bus_evt || per_hit) begin
         per_cnt <= '0;
      end else begin
         per_cnt <= per_cnt + CNT_ONE;
      end
   end

   // results, each held until the next conversion of its kind (temperature or input) completes
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         temp_m <= WORD_ZERO;
         adc_m <= WORD_ZERO;
         res_tgl <= 1'b0;
         over_temp_o <= 1'b0;
      end else if (conv_end) begin
         res_tgl <= ~res_tgl;
         if (is_temp) begin
            temp_m <= {adc_code_i, RESULT_PAD};
            over_temp_o <= $signed(adc_code_i[9:1]) >= $signed(cfg_m.toti);
         end else begin
            adc_m <= {adc_code_i, RESULT_PAD};
         end
      end
   end

   assign track_hold_o = (mst == M_CONV);
   assign conv_power_o = (mst == M_CONV);
   assign ref_amp_on_o = (mst == M_CONV) & internal_ref;
   assign reference_switch_o = internal_ref;
   assign conv_osc_en_o = auto_ok | (mst != M_IDLE);
   assign mux_sel_o = cfg_m.channel;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_pin_hold_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (mst == M_IDLE && pin_fall) |=> track_hold_o && cnt == '0)
      else $error("pin edge did not start conversion");
   a_auto_bus_conv: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (mst == M_IDLE && auto_ok && bus_evt && !pin_fall) |=> mst == M_DELAY)
      else $error("bus transaction did not launch conversion");
   a_osc_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (auto_ok && bus_evt) |=> per_cnt == '0)
      else $error("oscillator period not restarted");
   a_bus_delay_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (mst == M_IDLE && auto_ok && bus_evt && !pin_fall) |-> ##30 !track_hold_o ##1 track_hold_o)
      else $error("hold delay after transaction wrong");
   a_conv_temp_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ($rose(track_hold_o) && is_temp) |-> ##300 $fell(track_hold_o))
      else $error("temperature conversion length wrong");
   a_conv_ain_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ($rose(track_hold_o) && !is_temp) |-> ##150 $fell(track_hold_o))
      else $error("input conversion length wrong");
   a_ref_amp_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ref_amp_on_o |-> conv_power_o && reference_switch_o)
      else $error("reference amplifier on outside conversion");
   a_result_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $changed(temp_m) |-> $past(conv_end) && $past(is_temp))
      else $error("result changed without conversion end");
   a_over_temp_cmp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (conv_end && is_temp) |=> over_temp_o == ($signed($past(adc_code_i[9:1])) >= $signed(cfg_m.toti)))
      else $error("overtemperature compare wrong");
   a_shutdown_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (cfg_m.shutdown && mst == M_IDLE && !pin_fall) |=> mst == M_IDLE)
      else $error("conversion started in shutdown");
   a_addr_ack: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
      (lst == L_ADDR && scl_fall && last_bit && !start_det && !stop_det && shreg[7:1] == my_addr)
      |=> lst == L_ACK && !sda_oe_n_o)
      else $error("own address not acknowledged");
   c_pin_conv: cover property (@(posedge clk_i) disable iff (!rst_n_i) pin_fall && mst == M_IDLE);
   c_auto_conv: cover property (@(posedge clk_i) disable iff (!rst_n_i) dly_end);
   c_temp_done: cover property (@(posedge clk_i) disable iff (!rst_n_i) conv_end && is_temp);
   c_bus_read: cover property (@(posedge link_clk_i) disable iff (!rst_n_i) lst == L_RACK);
   c_period_conv: cover property (@(posedge clk_i) disable iff (!rst_n_i) per_hit && mst == M_IDLE);
endmodule
`default_nettype wire

// ==== tb/tac_bus_master.sv ====
// two-wire bus master model facing the serial port
`timescale 1ns/1ps
`default_nettype none
module tac_bus_master (
   input wire logic link_clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_rel_o
);
   // ----------------------------------------------------------------
   // bus phases, every access begins here
   // ----------------------------------------------------------------
   initial begin
      scl_o = 1'b1;
      sda_rel_o = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge link_clk_i);
   endtask
   task automatic start_cond();
      sda_rel_o <= 1'b1;
      wt(8);
      scl_o <= 1'b1;
      wt(8);
      sda_rel_o <= 1'b0;
      wt(8);
      scl_o <= 1'b0;
      wt(8);
   endtask
   task automatic stop_cond();
      sda_rel_o <= 1'b0;
      wt(8);
      scl_o <= 1'b1;
      wt(8);
      sda_rel_o <= 1'b1;
      wt(8);
   endtask
   // eight data bits then the acknowledge bit, msb first
   task automatic byte_io(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         sda_rel_o <= d[i];
         wt(6);
         scl_o <= 1'b1;
         wt(4);
         q[i] = sda_i;
         wt(4);
         scl_o <= 1'b0;
         wt(4);
      end
   endtask
endmodule
`default_nettype wire

// ==== tb/test_tac_conv_ctrl.sv ====
// self-checking bench of the conversion controller
`timescale 1ns/1ps
`default_nettype none
module test_tac_conv_ctrl;
   import tac_pkg::*;
   localparam logic [3:0] BASE = 4'h9; // arbitrary value
   localparam int LEN_T = T_CONV_TEMP_NS * CLK_MHZ / 1000;
   localparam int LEN_A = T_CONV_AIN_NS * CLK_MHZ / 1000;
   localparam int LEN_P = T_AUTO_NS * CLK_MHZ / 1000;
   logic clk_i = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n = 1'b0;
   logic pin = 1'b1;
   logic gnd = 1'b1;
   logic [2:0] strap;
   logic [6:0] dev;
   logic [9:0] code;
   logic scl, sda_rel, sda_o, sda_oe_n, sda_w, th, ref_amp, ref_sw, pwr, osc, ot;
   logic [2:0] mux;
   logic [15:0] mdl [8];
   int n_mismatch = 0;
   int comparisons = 0;
   assign sda_w = sda_rel & (sda_oe_n | sda_o);
   always #50 clk_i = ~clk_i;
   initial begin
      #3;
      forever #6 link_clk = ~link_clk;
   end
   tac_conv_ctrl #(.ADDR_BASE(BASE)) tac_conv_ctrl_inst (.clk_i(clk_i), .rst_n_i(rst_n),
      .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n), .conversion_start_pin_i(pin),
      .reference_input_pin_grounded_i(gnd), .bus_addr_select_bit0_i(strap[0]),
      .bus_addr_select_bit1_i(strap[1]), .bus_addr_select_bit2_i(strap[2]),
      .adc_code_i(code), .track_hold_o(th), .mux_sel_o(mux), .ref_amp_on_o(ref_amp),
      .reference_switch_o(ref_sw), .conv_power_o(pwr), .conv_osc_en_o(osc),
      .over_temp_o(ot));
   tac_bus_master tac_bus_master_inst (.link_clk_i(link_clk), .sda_i(sda_w), .scl_o(scl),
      .sda_rel_o(sda_rel));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // quarter degrees from a result word
   function automatic int deg4(input logic [15:0] r);
      return r[15] ? int'(r[14:6]) - 512 : int'(r[14:6]);
   endfunction
   task automatic bus_wr(input logic [6:0] a, input logic [2:0] p, input logic [15:0] v,
      input int nb, output logic nack);
      logic [8:0] q;
      tac_bus_master_inst.start_cond();
      tac_bus_master_inst.byte_io({a, 2'b01}, q);
      nack = q[0];
      tac_bus_master_inst.byte_io({5'h00, p, 1'b1}, q);
      for (int i = 0; i < nb; i++) begin
         tac_bus_master_inst.byte_io({(i == 0) ? v[15:8] : v[7:0], 1'b1}, q);
      end
      tac_bus_master_inst.stop_cond();
   endtask
   task automatic bus_rd(input logic setp, input logic [2:0] p, output logic [15:0] v);
      logic [8:0] q;
      logic n;
      if (setp) begin
         bus_wr(dev, p, 16'h0000, 0, n);
      end
      tac_bus_master_inst.start_cond();
      tac_bus_master_inst.byte_io({dev, 2'b11}, q);
      tac_bus_master_inst.byte_io(9'h1fe, q);
      v[15:8] = q[8:1];
      tac_bus_master_inst.byte_io(9'h1ff, q);
      v[7:0] = q[8:1];
      tac_bus_master_inst.stop_cond();
   endtask
   task automatic conv(input int lo, input int hi, input int len);
      int n;
      n = 0;
      while (th !== 1'b1 && n < hi + 10) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk("start_delay", {15'h0, n >= lo && n <= hi}, 16'h0001);
      if (th !== 1'b1) begin
         stop_test();
      end
      chk("ref_amp", {14'h0, ref_amp, pwr}, {14'h0, gnd, 1'b1});
      n = 0;
      while (th === 1'b1 && n < 400) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk("hold_len", 16'(n), 16'(len));
      if (th === 1'b1) begin
         stop_test();
      end
      chk("power_off", {13'h0, ref_amp, pwr, th}, 16'h0000);
   endtask
   task automatic pin_conv(input logic [9:0] c, input int len);
      @(posedge clk_i);
      code <= c;
      pin <= 1'b0;
      conv(2, 6, len);
      @(posedge clk_i);
      pin <= 1'b1;
      repeat (5) @(posedge clk_i);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      #5000000;
      n_mismatch++;
      stop_test();
   end
   initial begin
      logic [15:0] v;
      logic nk;
      logic [9:0] c;
      logic [9:0] tcode [5];
      int tq [5];
      tcode = '{10'h39c, 10'h064, 10'h0c8, 10'h3ff, 10'h1f4};
      tq = '{-100, 100, 200, -1, 500};
      void'($urandom(32'h5684c518));
      strap = 3'($urandom);
      dev = {BASE, strap};
      code = 10'($urandom);
      foreach (mdl[i]) mdl[i] = 16'h0000;
      repeat (2) @(posedge clk_i);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk_i);
      bus_rd(1'b0, P_TEMP, v);
      chk("temp_reset", v, mdl[0]);
      conv(28, 40, LEN_T);
      mdl[0] = {code, RESULT_PAD};
      bus_wr(dev, P_CFG2, 16'h8000, 1, nk);
      repeat (400) @(posedge clk_i);
      bus_wr(dev, P_TEMP, 16'hffff, 2, nk);
      bus_rd(1'b1, P_TEMP, v);
      chk("temp_ro", v, mdl[0]);
      $display("test auto_read done");
      bus_wr({BASE, ~strap}, P_CFG, 16'h4000, 1, nk);
      chk("foreign_nack", {15'h0, nk}, 16'h0001);
      bus_rd(1'b1, P_CFG, v);
      chk("cfg_kept", {8'h00, v[15:8]}, 16'h0000);
      bus_wr(dev, P_TOTI, 16'h3200, 2, nk);
      chk("ack", {15'h0, nk}, 16'h0000);
      mdl[3] = 16'h3200;
      bus_rd(1'b1, P_TOTI, v);
      chk("limit", v, mdl[3]);
      mdl[2] = 16'($urandom);
      bus_wr(dev, P_THYST, mdl[2], 2, nk);
      bus_rd(1'b1, P_THYST, v);
      chk("hyst", v, mdl[2]);
      $display("test bus_access done");
      foreach (tcode[i]) begin
         pin_conv(tcode[i], LEN_T);
         mdl[0] = {tcode[i], RESULT_PAD};
         bus_rd(1'b1, P_TEMP, v);
         chk("temp", v, mdl[0]);
         chk("deg", 16'(deg4(v)), 16'(tq[i]));
         chk("over_temp", {15'h0, ot},
            {15'h0, $signed(tcode[i][9:1]) >= $signed(mdl[3][15:7])});
      end
      $display("test temperature done");
      for (int ch = 1; ch <= 4; ch++) begin
         c = 10'($urandom);
         @(posedge clk_i);
         gnd <= ch[0];
         bus_wr(dev, P_CFG, {3'(ch), 13'h0000}, 1, nk);
         repeat (5) @(posedge clk_i);
         chk("mux", {13'h0, mux}, 16'(ch));
         chk("ref_switch", {15'h0, ref_sw}, {15'h0, gnd});
         pin_conv(c, LEN_A);
         mdl[4] = {c, RESULT_PAD};
         bus_rd(1'b1, P_ADC, v);
         chk("adc", v, mdl[4]);
         bus_rd(1'b1, P_TEMP, v);
         chk("temp_kept", v, mdl[0]);
         chk("ot_kept", {15'h0, ot}, 16'h0001);
      end
      $display("test channels done");
      bus_wr(dev, P_CFG, 16'h0100, 1, nk);
      bus_wr(dev, P_CFG2, 16'h0000, 1, nk);
      repeat (60) @(posedge clk_i);
      #1;
      chk("shutdown_idle", {14'h0, th, osc}, 16'h0000);
      bus_wr(dev, P_CFG, 16'h0000, 1, nk);
      conv(28, 40, LEN_T);
      chk("osc_on", {15'h0, osc}, 16'h0001);
      conv(LEN_P - LEN_T - 40, LEN_P - LEN_T - 20, LEN_T);
      $display("test shutdown done");
      stop_test();
   end
endmodule
`default_nettype wire
